// ==== rtl/erd_diag.sv ====
// error-report network diagnostics and fault-tolerant self-test logic
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module erd_diag import erd_pkg::*; #(
   parameter int PERM_WIN_CYC = ERD_PERM_WIN_CYC,
   parameter int NPAR = ERD_PAR_W
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic is_checker,
   input wire logic [ERD_LOC_W-1:0] own_loc,
   input wire logic rx_bit,
   input wire logic rx_valid,
   input wire logic path_b_bit,
   input wire logic cfg_wr,
   input wire logic [3:0] cfg_iac_type,
   input wire logic cfg_access_mode,
   input wire logic cfg_from_own_module,
   input wire logic cfg_test_en,
   input wire logic [NPAR-1:0] cfg_parity_test,
   input wire logic sel_access,
   input wire logic [1:0] toggle_bits,
   input wire logic [NPAR-1:0] bus_parity_check_input,
   input wire logic [NPAR-1:0] bus_parity_calc,
   input wire logic parity_sample,
   input wire logic test_report_cmd,
   input wire logic [31:0] test_type_pattern,
   input wire logic log_valid,
   input wire logic log_sw_write,
   input wire logic retry_start,
   input wire logic ap_read_req,
   input wire logic ap_read_claimed,
   input wire logic frc_mismatch,
   output logic [1:0] bus_error_report_line,
   output logic [1:0] module_error_report_line,
   output logic origin_flag,
   output logic testing_enable,
   output logic dummy_op,
   output logic bad_access_indication,
   output logic frc_error,
   output logic report_err,
   output logic [ERD_TYPE_W-1:0] last_type,
   output logic permanent
);
   localparam int LW = ERD_TYPE_W + ERD_LOC_W + 2;
   localparam int CW = $clog2(ERD_MSG_BITS + 1);
   localparam int WW = $clog2(PERM_WIN_CYC + 1);
   localparam int TW = $clog2(ERD_TRANS_WAIT_CYC + 1);
   localparam int BW = $clog2(ERD_BUS_TO_CYC + 1);

   function automatic logic [ERD_TYPE_W-1:0] prio_type(input logic [31:0] p);
      logic [ERD_TYPE_W-1:0] t;
      t = ERD_TYPE_NOOP;
      for (int i = 0; i < 32; i++) begin
         if (p[i]) begin
            t = ERD_TYPE_W'(i);
         end
      end
      return t;
   endfunction

   function automatic logic msg_parity(input logic [LW-3:0] f);
      return ^f;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // receive: two copies of one report, each type+loc+parity+invalid
   logic [LW-1:0] shreg;
   logic [LW-1:0] copy1;
   logic [CW-1:0] bitcnt;
   logic copy_sel;
   logic path_mis;
   logic copy_done;
   logic c1_ok;
   logic c2_ok;
   logic both_bad;
   logic [LW-1:0] next_shreg;

   assign next_shreg = {shreg[LW-2:0], rx_bit};
   assign copy_done = rx_valid && bitcnt == CW'(LW - 1);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         shreg <= '0;
         bitcnt <= '0;
         copy_sel <= 1'b0;
         copy1 <= '0;
         path_mis <= 1'b0;
      end else if (rx_valid) begin
         shreg <= next_shreg;
         // disagreement of the second internal path counts as line error
         // kept across both copies, cleared only once the pair is judged
         path_mis <= !(copy_done && copy_sel) && (path_mis || (rx_bit ^ path_b_bit));
         if (copy_done) begin
            bitcnt <= '0;
            copy_sel <= ~copy_sel;
            if (!copy_sel) begin
               copy1 <= next_shreg;
            end
         end else begin
            bitcnt <= bitcnt + 1'b1;
         end
      end
   end

   // parity sits just above the invalid marker; copies must agree
   logic p_ok1;
   logic p_ok2;
   logic copies_eq;
   logic msg_err;
   logic in_invalid;
   assign p_ok1 = msg_parity(copy1[LW-1:2]) == copy1[1];
   assign p_ok2 = msg_parity(next_shreg[LW-1:2]) == next_shreg[1];
   assign copies_eq = copy1[LW-1:1] == next_shreg[LW-1:1];
   assign msg_err = !p_ok1 || !p_ok2 || !copies_eq || path_mis || (rx_bit ^ path_b_bit);
   assign in_invalid = next_shreg[0];
   assign c1_ok = p_ok1;
   assign c2_ok = p_ok2;
   assign both_bad = !c1_ok && !c2_ok;
   logic pair_done;
   assign pair_done = copy_done && copy_sel;

   //////////////////////////////////////////////////////////////////////////
   // relay marking and origin flag
   logic relay_invalid;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         origin_flag <= 1'b0;
         relay_invalid <= 1'b0;
         report_err <= 1'b0;
      end else if (pair_done) begin
         report_err <= msg_err;
         relay_invalid <= msg_err;
         if (msg_err && !in_invalid) begin
            origin_flag <= 1'b1;
         end
      end else if (retry_start) begin
         origin_flag <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // classification: permanent window, consecutive reporting errors
   logic [WW-1:0] win_cnt;
   logic [ERD_LOC_W-1:0] last_ere_loc;
   logic [ERD_LOC_W-1:0] rx_loc;
   logic [ERD_TYPE_W-1:0] rx_type;
   logic is_ere;
   assign rx_loc = next_shreg[LW-1-ERD_TYPE_W -: ERD_LOC_W];
   assign rx_type = next_shreg[LW-1 -: ERD_TYPE_W];
   assign is_ere = rx_type == ERD_TYPE_ERE;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         win_cnt <= '0;
         last_ere_loc <= '0;
         permanent <= 1'b0;
         last_type <= ERD_TYPE_NOOP;
      end else if (pair_done && !both_bad) begin
         last_type <= c2_ok ? rx_type : copy1[LW-1 -: ERD_TYPE_W];
         if (is_ere) begin
            permanent <= win_cnt != '0 && rx_loc == last_ere_loc;
            last_ere_loc <= rx_loc;
            win_cnt <= WW'(PERM_WIN_CYC);
         end else begin
            permanent <= 1'b0;
         end
      end else if (win_cnt != '0) begin
         win_cnt <= win_cnt - 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // report generation: skip retry, wait transient period (error reports only), then send
   erd_state_t state;
   logic [TW-1:0] wait_cnt;
   logic [ERD_TYPE_W-1:0] tx_type;
   logic [LW-1:0] tx_msg;
   logic [CW-1:0] tx_cnt;
   logic split;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ERD_IDLE;
         wait_cnt <= '0;
         tx_type <= ERD_TYPE_NOOP;
      end else begin
         unique case (state)
            ERD_IDLE: begin
               if (pair_done && msg_err) begin
                  // two reporting errors in a row: break the loop
                  tx_type <= (last_type == ERD_TYPE_ERE) ? ERD_TYPE_UCA : ERD_TYPE_ERE;
                  wait_cnt <= TW'(ERD_TRANS_WAIT_CYC);
                  state <= ERD_WAIT;
               end else if (test_report_cmd && testing_enable) begin
                  tx_type <= prio_type(test_type_pattern);
                  // one cycle in wait lets the frame pick up the new type
                  wait_cnt <= '0;
                  state <= ERD_WAIT;
               end
            end
            ERD_WAIT: begin
               if (wait_cnt == '0) begin
                  state <= ERD_COPY1;
               end else begin
                  wait_cnt <= wait_cnt - 1'b1;
               end
            end
            ERD_COPY1: begin
               if (tx_cnt == CW'(LW - 1)) begin
                  state <= ERD_COPY2;
               end
            end
            ERD_COPY2: begin
               if (tx_cnt == CW'(LW - 1)) begin
                  state <= ERD_IDLE;
               end
            end
         endcase
      end
   end

   logic [LW-1:0] tx_frame;
   // originator clears the invalid marker
   assign tx_frame = {tx_type, own_loc, msg_parity({tx_type, own_loc}), 1'b0};
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_cnt <= '0;
         tx_msg <= '0;
      end else if (state == ERD_COPY1 || state == ERD_COPY2) begin
         tx_cnt <= (tx_cnt == CW'(LW - 1)) ? '0 : tx_cnt + 1'b1;
         if (state == ERD_COPY1 && tx_cnt == CW'(LW - 1)) begin
            // second copy restarts from a fresh frame, not the emptied shifter
            tx_msg <= tx_frame;
         end else begin
            tx_msg <= {tx_msg[LW-2:0], 1'b0};
         end
      end else begin
         tx_cnt <= '0;
         tx_msg <= tx_frame;
      end
   end

   // split drive latches on fault conditions until the next report with at least one good copy
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         split <= 1'b0;
      end else if ((pair_done && both_bad) || (retry_start && !log_valid)
                   || (log_sw_write && !log_valid)) begin
         split <= 1'b1;
      end else if (pair_done) begin
         split <= 1'b0;
      end
   end

   logic tx_bit;
   logic sending;
   assign sending = state == ERD_COPY1 || state == ERD_COPY2;
   assign tx_bit = sending && tx_msg[LW-1];
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_error_report_line <= 2'h0;
         module_error_report_line <= 2'h0;
      end else begin
         // relayed marker set on both lines of both networks
         bus_error_report_line[0] <= (tx_bit && !(split && is_checker)) ||
                                     (rx_valid && relay_invalid);
         bus_error_report_line[1] <= (tx_bit && !(split && !is_checker)) ||
                                     (rx_valid && relay_invalid);
         module_error_report_line <= {2{tx_bit || (rx_valid && relay_invalid)}};
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // access selection and testing enable
   logic access_ok;
   logic selected;
   assign access_ok = cfg_access_mode && !cfg_from_own_module;
   assign selected = !access_ok || toggle_bits != 2'h0 || sel_access;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         testing_enable <= 1'b0;
         dummy_op <= 1'b0;
      end else begin
         dummy_op <= cfg_wr && cfg_iac_type == ERD_IAC_REG_LOGICAL && !selected;
         if (cfg_wr && cfg_iac_type == ERD_IAC_REG_LOGICAL && selected) begin
            testing_enable <= cfg_test_en;
         end else if (state == ERD_IDLE && test_report_cmd && testing_enable) begin
            testing_enable <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // forced parity and comparator self-test
   logic [NPAR-1:0] chk_eff;
   assign chk_eff = bus_parity_check_input ^ (testing_enable ? cfg_parity_test : '0);
   // a real error on a tested input cancels the forced one; accepted loss
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         frc_error <= 1'b0;
      end else begin
         frc_error <= (parity_sample && chk_eff != bus_parity_calc) ||
                      (testing_enable && frc_mismatch);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // bus time-out on unclaimed read
   logic [BW-1:0] to_cnt;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         to_cnt <= '0;
         bad_access_indication <= 1'b0;
      end else begin
         bad_access_indication <= 1'b0;
         if (ap_read_req && !ap_read_claimed) begin
            if (to_cnt == BW'(ERD_BUS_TO_CYC - 1)) begin
               bad_access_indication <= 1'b1;
               to_cnt <= '0;
            end else begin
               to_cnt <= to_cnt + 1'b1;
            end
         end else begin
            to_cnt <= '0;
         end
      end
   end

   chk_send_twice: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state == ERD_COPY1 && tx_cnt == CW'(LW - 1) |=> state == ERD_COPY2)
      else $error("report not repeated");
   chk_origin_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pair_done && msg_err && !in_invalid |=> origin_flag && relay_invalid)
      else $error("origin flag not set");
   chk_no_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pair_done && msg_err && in_invalid && !origin_flag |=> !origin_flag)
      else $error("origin flag set wrongly");
   chk_wait_first: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state == ERD_IDLE && pair_done && msg_err |=> state == ERD_WAIT)
      else $error("no transient wait");
   chk_loop_break: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state == ERD_IDLE && pair_done && msg_err && last_type == ERD_TYPE_ERE
      |=> tx_type == ERD_TYPE_UCA)
      else $error("loop not broken");
   chk_te_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      state == ERD_IDLE && test_report_cmd && testing_enable && !cfg_wr |=> !testing_enable)
      else $error("testing enable kept");
   chk_force_par: assert property (@(posedge sys_clk) disable iff (!rst_b)
      testing_enable && parity_sample && cfg_parity_test != '0 &&
      bus_parity_check_input == bus_parity_calc |=> frc_error)
      else $error("forced parity missed");
   chk_split_drv: assert property (@(posedge sys_clk) disable iff (!rst_b)
      split && is_checker && sending |=> !bus_error_report_line[0] || $past(rx_valid))
      else $error("checker drove line zero");
endmodule

// ==== rtl/erd_pkg.sv ====
// package: constants for the error-report network diagnostics block
package erd_pkg;
   localparam int ERD_MSG_BITS = 50;
   localparam int ERD_TYPE_W = 5;
   localparam int ERD_LOC_W = 16;
   localparam int ERD_PAR_W = 4;
   localparam logic [4:0] ERD_TYPE_NOOP = 5'h00;
   localparam logic [4:0] ERD_TYPE_ERE = 5'h1b;
   localparam logic [4:0] ERD_TYPE_UCA = 5'h1f;
   localparam logic [4:0] ERD_TYPE_PARITY = 5'h1a;
   localparam logic [4:0] ERD_TYPE_TIMEOUT = 5'h14;
   localparam int ERD_PERM_WIN_NS = 100000;
   localparam int ERD_CLK_NS = 10;
   localparam int ERD_PERM_WIN_CYC = ERD_PERM_WIN_NS / ERD_CLK_NS;
   localparam int ERD_TRANS_WAIT_NS = 2000;
   localparam int ERD_TRANS_WAIT_CYC = ERD_TRANS_WAIT_NS / ERD_CLK_NS;
   localparam int ERD_BUS_TO_NS = 2560;
   localparam int ERD_BUS_TO_CYC = ERD_BUS_TO_NS / ERD_CLK_NS;
   localparam logic [3:0] ERD_IAC_REG_LOGICAL = 4'h2;
   typedef enum logic [1:0] {ERD_IDLE, ERD_COPY1, ERD_COPY2, ERD_WAIT} erd_state_t;
endpackage

// ==== verification/erd_peer.sv ====
// peer unit model that sends duplicated serial error reports
`timescale 1ns/1ps
module erd_peer import erd_pkg::*; (
   input wire logic sys_clk,
   output logic rx_bit,
   output logic rx_valid,
   output logic path_b_bit
);
   initial begin
      rx_bit = 1'b0;
      rx_valid = 1'b0;
      path_b_bit = 1'b0;
   end
   task automatic send_pair(input logic [4:0] typ, input logic [15:0] loc,
         input logic bad_par, inv, path_err);
      logic [22:0] msg;
      msg = {typ, loc, ^{typ, loc}, inv};
      for (int i = 0; i < 46; i++) begin
         @(posedge sys_clk);
         #1;
         rx_valid = 1'b1;
         rx_bit = msg[22 - (i % 23)] ^ (bad_par && i == 21);
         path_b_bit = rx_bit ^ (path_err && i == 30);
      end
      @(posedge sys_clk);
      #1;
      rx_valid = 1'b0;
      // released lines float: never leave the last bit standing
      rx_bit = ~rx_bit;
      path_b_bit = ~path_b_bit;
   endtask
endmodule

// ==== verification/erd_diag_tb_top.sv ====
// self-checking bench for the error-report diagnostics block
`timescale 1ns/1ps
module erd_diag_tb_top import erd_pkg::*;;
   localparam int PWIN = 100;
   // iac type, access, own module, toggles, select, enable, exp enable, exp dummy
   localparam logic [11:0] CFG_TAB [6] = '{12'b0010_1_0_00_0_1_0_1, 12'b0010_1_0_00_1_1_1_0,
      12'b0010_1_1_00_0_0_0_0, 12'b0010_1_0_01_0_1_1_0, 12'b0011_1_0_00_1_0_1_0,
      12'b0010_0_0_00_0_0_0_0};
   // bad parity, invalid in, path b slip, exp error, exp origin
   localparam logic [4:0] RX_TAB [4] = '{5'b000_00, 5'b100_11, 5'b110_10, 5'b001_11};
   logic sys_clk = 1'b0, rst_b = 1'b0, is_checker = 1'b0, cfg_wr = 1'b0;
   logic cfg_access_mode = 1'b0, cfg_from_own_module = 1'b0, cfg_test_en = 1'b0;
   logic sel_access = 1'b0, parity_sample = 1'b0, test_report_cmd = 1'b0, log_valid = 1'b0;
   logic log_sw_write = 1'b0, retry_start = 1'b0, ap_read_req = 1'b0, ap_read_claimed = 1'b0;
   logic frc_mismatch = 1'b0, rx_bit, rx_valid, path_b_bit;
   logic [15:0] own_loc = 16'h00c3;
   logic [3:0] cfg_iac_type = 4'h0, cfg_parity_test = 4'h0, m;
   logic [3:0] bus_parity_check_input = 4'h5, bus_parity_calc = 4'h5;
   logic [1:0] toggle_bits = 2'h0, bus_error_report_line, module_error_report_line;
   logic [31:0] test_type_pattern = 32'h0;
   logic [4:0] last_type, typ, mt;
   logic origin_flag, testing_enable, dummy_op, bad_access_indication, frc_error;
   logic report_err, permanent, other;
   logic [11:0] row;
   int n_fail = 0, compares = 0, cyc = 0, n;
   erd_diag #(.PERM_WIN_CYC(PWIN), .NPAR(4)) erd_diag_i (.sys_clk, .rst_b, .is_checker,
      .own_loc, .rx_bit, .rx_valid, .path_b_bit, .cfg_wr, .cfg_iac_type, .cfg_access_mode,
      .cfg_from_own_module, .cfg_test_en, .cfg_parity_test, .sel_access, .toggle_bits,
      .bus_parity_check_input, .bus_parity_calc, .parity_sample, .test_report_cmd,
      .test_type_pattern, .log_valid, .log_sw_write, .retry_start, .ap_read_req,
      .ap_read_claimed, .frc_mismatch, .bus_error_report_line, .module_error_report_line,
      .origin_flag, .testing_enable, .dummy_op, .bad_access_indication, .frc_error,
      .report_err, .last_type, .permanent);
   erd_peer erd_peer_i (.sys_clk, .rx_bit, .rx_valid, .path_b_bit);
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask
   task automatic chk_type(input logic [4:0] got, input logic [4:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic test_done();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic pulse(ref logic s);
      // a clock edge between two strobes keeps them apart
      tick(1);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic do_reset();
      rst_b = 1'b0;
      tick(4);
      rst_b = 1'b1;
   endtask
   task automatic cfg_write(input logic [3:0] t, input logic acc, own, en,
         input logic [3:0] ptest);
      cfg_iac_type = t;
      cfg_access_mode = acc;
      cfg_from_own_module = own;
      cfg_test_en = en;
      cfg_parity_test = ptest;
      pulse(cfg_wr);
   endtask
   task automatic par_probe(input logic [3:0] chk, input logic exp);
      bus_parity_check_input = chk;
      pulse(parity_sample);
      chk_bit(frc_error, exp, "forced parity");
   endtask
   // type read on the unit's own bus line; oth shows whether the other line is driven
   task automatic get_tx(input logic sel, output logic [4:0] t, output logic [4:0] mt,
         output int w, output logic oth);
      w = 0;
      oth = 1'b0;
      while (bus_error_report_line[sel] !== 1'b1 && w < 400) begin
         tick(1);
         w++;
      end
      for (int i = 4; i >= 0; i--) begin
         t[i] = bus_error_report_line[sel];
         mt[i] = module_error_report_line[0];
         oth |= bus_error_report_line[!sel];
         tick(1);
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      chk_bit(testing_enable, 1'b0, "enable at reset");
      for (int r = 0; r < 4; r++) begin
         do_reset();
         erd_peer_i.send_pair(ERD_TYPE_PARITY, own_loc, RX_TAB[r][4], RX_TAB[r][3],
            RX_TAB[r][2]);
         chk_bit(report_err, RX_TAB[r][1], "report err");
         chk_bit(origin_flag, RX_TAB[r][0], "origin");
      end
      get_tx(1'b0, typ, mt, n, other);
      chk_bit(n >= 195 && n <= 205, 1'b1, "report wait");
      chk_type(typ, ERD_TYPE_ERE, "report type");
      chk_type(mt, ERD_TYPE_ERE, "module line type");
      chk_bit(other, 1'b1, "both bus lines");
      do_reset();
      erd_peer_i.send_pair(ERD_TYPE_ERE, own_loc, 1'b0, 1'b0, 1'b0);
      erd_peer_i.send_pair(ERD_TYPE_PARITY, own_loc, 1'b1, 1'b0, 1'b0);
      get_tx(1'b0, typ, mt, n, other);
      chk_type(typ, ERD_TYPE_UCA, "loop breaker");
      chk_type(last_type, ERD_TYPE_PARITY, "one good copy");
      // g=0 repeat in window, g=1 outside window, g=2 other area
      for (int g = 0; g < 3; g++) begin
         do_reset();
         erd_peer_i.send_pair(ERD_TYPE_ERE, own_loc, 1'b0, 1'b0, 1'b0);
         tick(g == 1 ? PWIN + 20 : 0);
         erd_peer_i.send_pair(ERD_TYPE_ERE, own_loc ^ 16'(g == 2), 1'b0, 1'b0, 1'b0);
         chk_bit(permanent, g == 0, "permanent");
      end
      $display("receive test done");
      do_reset();
      for (int r = 0; r < 6; r++) begin
         row = CFG_TAB[r];
         toggle_bits = row[5:4];
         sel_access = row[3];
         cfg_write(row[11:8], row[7], row[6], row[2], 4'h0);
         chk_bit(testing_enable, row[1], "enable");
         chk_bit(dummy_op, row[0], "dummy op");
      end
      toggle_bits = 2'h0;
      cfg_write(4'h2, 1'b0, 1'b0, 1'b1, 4'h0);
      frc_mismatch = 1'b1;
      tick(1);
      chk_bit(frc_error, 1'b1, "frc on");
      cfg_write(4'h2, 1'b0, 1'b0, 1'b0, 4'h0);
      tick(1);
      chk_bit(frc_error, 1'b0, "frc off");
      frc_mismatch = 1'b0;
      for (int i = 0; i < 5; i++) begin
         m = 4'h1 << i;
         cfg_write(4'h2, 1'b0, 1'b0, 1'b1, m);
         par_probe(4'h5, m != 4'h0);
         par_probe(4'h5 ^ m, 1'b0);
      end
      $display("config test done");
      do_reset();
      ap_read_req = 1'b1;
      n = 0;
      while (bad_access_indication !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      chk_bit(n >= 250 && n <= 260, 1'b1, "timeout");
      ap_read_claimed = 1'b1;
      other = 1'b0;
      repeat (300) begin
         tick(1);
         other |= bad_access_indication;
      end
      chk_bit(other, 1'b0, "claimed read");
      ap_read_req = 1'b0;
      $display("timeout test done");
      do_reset();
      cfg_write(4'h2, 1'b0, 1'b0, 1'b1, 4'h0);
      pulse(log_sw_write);
      test_type_pattern = 32'h0400_0030;
      pulse(test_report_cmd);
      chk_bit(testing_enable, 1'b0, "enable after command");
      get_tx(1'b0, typ, mt, n, other);
      chk_type(typ, ERD_TYPE_PARITY, "test report type");
      chk_bit(other, 1'b0, "split drive");
      // let the master frame finish, then repeat as checker
      is_checker = 1'b1;
      tick(50);
      cfg_write(4'h2, 1'b0, 1'b0, 1'b1, 4'h0);
      pulse(test_report_cmd);
      get_tx(1'b1, typ, mt, n, other);
      chk_type(typ, ERD_TYPE_PARITY, "checker report type");
      chk_bit(other, 1'b0, "checker split drive");
      $display("test report done");
      test_done();
   end
endmodule
